// ### verif/rsc_far_model.sv
// Far-side model: supply monitors, reset pin, watchdog, debugger, scan
`timescale 1ns/1ps
module rsc_far_model #(
   parameter int SCAN_CYC = 5
) (
   input wire logic clk_sys_i,
   input wire logic [5:0] cmd_i,
   input wire logic scan_start_i,
   output logic por_low_o,
   output logic brownout_o,
   output logic pin_n_o,
   output logic watchdog_o,
   output logic dbg_o,
   output logic scan_done_o
);
   int cnt = 0;
   // Sources follow the commanded levels
   assign por_low_o = cmd_i[0];
   assign brownout_o = cmd_i[1];
   assign pin_n_o = ~cmd_i[2];
   assign watchdog_o = cmd_i[3];
   assign dbg_o = cmd_i[5];
   // Scan ends some cycles after start, drops with start
   always @(posedge clk_sys_i) begin
      cnt <= scan_start_i ? cnt + 1 : 0;
   end
   assign scan_done_o = scan_start_i && (cnt >= SCAN_CYC);
endmodule

// ### verif/tb_top.sv
// Self-checking bench for the reset controller
`timescale 1ns/1ps
module tb_top;
   localparam int STU = 2;
   localparam logic [2:0] STARTUP_SEL = 3'h2;
   localparam int SCAN = 5;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rd;
   logic [31:0] hrdata;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic hsel = 1'b0;
   logic key = 1'b0;
   logic instr = 1'b0;
   logic pin_en = 1'b1;
   logic [1:0] scan_src = 2'h0;
   logic [5:0] cmd = 6'h00;
   logic [5:0] m;
   logic hrdy, hresp, por_low, brownout, pin_n, watchdog, dbg, scan_done, scan_start;
   logic fuse_rl, sys_rst, dbg_rst, tmr_rst;
   int errors = 0;
   int checks_done = 0;
   int seed = 4;
   int n;
   int fl_cnt = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   rsc_reset_controller #(.STARTUP_UNIT_CYC(STU)) rsc_reset_controller_i (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp),
      .por_low_i(por_low), .brownout_detector_i(brownout), .reset_pin_n_i(pin_n),
      .watchdog_timer_req_i(watchdog), .single_pin_debug_port_req_i(dbg),
      .reset_pin_function_field_i(pin_en), .startup_delay_fuse_field_i(STARTUP_SEL),
      .checksum_scan_source_field_i(scan_src), .io_register_unlock_key_i(key),
      .instr_retired_i(instr), .memory_checksum_scan_done_i(scan_done),
      .memory_checksum_scan_start_o(scan_start), .fuse_reload_o(fuse_rl),
      .sys_reset_o(sys_rst), .debug_reset_o(dbg_rst),
      .control_timer_override_reset_o(tmr_rst));

   rsc_far_model #(.SCAN_CYC(SCAN)) rsc_far_model_i (
      .clk_sys_i(clk_sys_i), .cmd_i(cmd), .scan_start_i(scan_start),
      .por_low_o(por_low), .brownout_o(brownout), .pin_n_o(pin_n), .watchdog_o(watchdog),
      .dbg_o(dbg), .scan_done_o(scan_done));

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys_i);
   endtask

   // One bounded wait for hready at a rising edge
   task automatic wait_rdy();
      n = 0;
      @(posedge clk_sys_i);
      while (hrdy !== 1'b1) begin
         n++;
         if (n > 100) begin
            errors++;
            summarize();
         end
         @(posedge clk_sys_i);
      end
   endtask

   // Single AHB-Lite word transfer, read data left in rd
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask

   // Unlock key then k retired instructions
   task automatic unlock(input int k);
      key <= 1'b1;
      tick(1);
      key <= 1'b0;
      repeat (k) begin
         instr <= 1'b1;
         tick(1);
         instr <= 1'b0;
         tick(1);
      end
   endtask

   // Release sources and time the initialisation
   task automatic boot();
      cmd <= 6'h00;
      n = 0;
      while (sys_rst !== 1'b0) begin
         tick(1);
         n++;
         if (n > 3000) begin
            errors++;
            summarize();
         end
      end
      chk("init_len", 32'h1,
          32'(n >= 9 + (STU << STARTUP_SEL) + (scan_src == 2'h3 ? 0 : SCAN)));
   endtask

   // Raise sources, check the domain resets, then boot
   task automatic hit(input logic [5:0] c);
      cmd <= c;
      tick(5);
      chk("sys_reset", 32'h1, 32'(sys_rst));
      chk("debug_reset", 32'(|(c & rsc_pkg::MASK_SUPPLY)), 32'(dbg_rst));
      chk("timer_reset", 32'(c[0]), 32'(tmr_rst));
      boot();
   endtask

   // Read flags, clear them with ones, read again
   task automatic flags(input logic [5:0] e);
      bus(32'h0, 1'b0, 32'h0);
      chk("flags", {26'h0, e}, rd);
      bus(32'h0, 1'b1, 32'h3f);
      bus(32'h0, 1'b0, 32'h0);
      chk("flags_clr", 32'h0, rd);
   endtask

   // Fuse reload length and scan hold, watched every cycle
   always @(posedge clk_sys_i) begin
      if (fuse_rl === 1'b1)
         fl_cnt++;
      else if (fl_cnt != 0) begin
         chk("fuse_reload", 32'(rsc_pkg::FUSE_LOAD_CYC), fl_cnt);
         fl_cnt = 0;
      end
      if (scan_start === 1'b1)
         chk("scan_hold", 32'h1, 32'(sys_rst));
   end

   // Main sequence
   initial begin
      cmd <= 6'h08;
      tick(5);
      rst_i <= 1'b0;
      tick(4);
      boot();
      flags(6'h01);
      bus(32'h4, 1'b0, 32'h0);
      chk("trigger_read", 32'h0, rd);
      bus(32'h40, 1'b1, 32'hff);
      bus(32'h40, 1'b0, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, 32'(hresp));
      $display("test registers done");
      bus(32'h4, 1'b1, 32'h1);
      tick(6);
      chk("locked", 32'h0, 32'(sys_rst));
      unlock(6);
      bus(32'h4, 1'b1, 32'h1);
      tick(6);
      chk("late", 32'h0, 32'(sys_rst));
      unlock(1);
      bus(32'h4, 1'b1, 32'h1);
      hit(6'h10);
      flags(6'h10);
      $display("test software done");
      // Pin reset disabled by its fuse must not reset or flag
      pin_en <= 1'b0;
      cmd <= 6'h04;
      tick(6);
      chk("pin_off", 32'h0, 32'(sys_rst));
      bus(32'h0, 1'b0, 32'h0);
      chk("pin_off_flag", 32'h0, rd);
      cmd <= 6'h00;
      tick(3);
      pin_en <= 1'b1;
      // Clear while the watchdog still requests: set wins
      cmd <= 6'h08;
      tick(5);
      bus(32'h0, 1'b1, 32'h3f);
      bus(32'h0, 1'b0, 32'h0);
      chk("set_wins", 32'h8, rd);
      // Boot with the checksum scan switched off
      scan_src <= 2'h3;
      boot();
      flags(6'h08);
      scan_src <= 2'h0;
      $display("test fuses done");
      repeat (12) begin
         m = 6'($random(seed)) & 6'h2e;
         if (m == 6'h00)
            m = 6'h04;
         hit(m);
         flags(m);
      end
      $display("test random done");
      hit(6'h01);
      flags(6'h01);
      $display("test power-on done");
      summarize();
   end
endmodule

// ### verilog/rsc_pkg.sv
// Shared constants for the reset controller block
package rsc_pkg;

   // System clock period in ns
   localparam int unsigned CLK_NS = 10;

   // Printed register offsets, kept as word indices
   localparam logic [7:0] IDX_CAUSE_FLAGS = 8'h00;
   localparam logic [7:0] IDX_SW_TRIGGER = 8'h01;

   // Cause flag bit positions
   localparam int unsigned FLAG_POR = 0;
   localparam int unsigned FLAG_BROWNOUT = 1;
   localparam int unsigned FLAG_PIN = 2;
   localparam int unsigned FLAG_WATCHDOG = 3;
   localparam int unsigned FLAG_SW = 4;
   localparam int unsigned FLAG_DBG = 5;
   localparam int unsigned NUM_SRC = 6;

   // Software trigger bit position
   localparam int unsigned SW_TRIGGER_BIT = 0;

   // Reset values
   localparam logic [5:0] FLAGS_RST = 6'h01;
   localparam logic [5:0] CAUSE_RST = 6'h01;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // Domain masks over the cause vector
   localparam logic [5:0] MASK_SUPPLY = 6'h03;
   localparam logic [5:0] MASK_POR = 6'h01;

   // Unlock window length in instructions
   localparam logic [2:0] UNLOCK_WINDOW_INSTR = 3'h4;

   // Fuse reload phase length in cycles
   localparam logic [15:0] FUSE_LOAD_CYC = 16'h0008;

   // Start-up delay unit, time and derived cycle count
   localparam int unsigned STARTUP_UNIT_NS = 1000;
   localparam int unsigned STARTUP_UNIT_CYC = (STARTUP_UNIT_NS + CLK_NS - 1) / CLK_NS;

   // Checksum scan source code meaning no scan at start-up
   localparam logic [1:0] SCAN_SRC_NONE = 2'h3;

   // Reset sequence states
   typedef enum logic [2:0] {
      RS_HOLD,
      RS_LOAD,
      RS_START,
      RS_SCAN,
      RS_RUN
   } rsc_state_t;

endpackage

// ### verilog/rsc_reset_controller.sv
// Reset controller: source merge, cause flags, domain resets, AHB-Lite registers
`timescale 1ns/1ps

module rsc_reset_controller #(
   parameter int unsigned STARTUP_UNIT_CYC = rsc_pkg::STARTUP_UNIT_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Reset sources from pins and monitors
   input wire logic por_low_i,
   input wire logic brownout_detector_i,
   input wire logic reset_pin_n_i,
   input wire logic watchdog_timer_req_i,
   input wire logic single_pin_debug_port_req_i,
   // Fuses, static while running
   input wire logic reset_pin_function_field_i,
   input wire logic [2:0] startup_delay_fuse_field_i,
   input wire logic [1:0] checksum_scan_source_field_i,
   // Change protection from the processor, same clock
   input wire logic io_register_unlock_key_i,
   input wire logic instr_retired_i,
   // Checksum scan handshake
   input wire logic memory_checksum_scan_done_i,
   output logic memory_checksum_scan_start_o,
   // Domain resets
   output logic fuse_reload_o,
   output logic sys_reset_o,
   output logic debug_reset_o,
   output logic control_timer_override_reset_o
);

   // Synchroniser stages for the asynchronous inputs
   logic [5:0] sync1_r;
   logic [5:0] sync2_r;
   logic por_s, brownout_s, pin_n_s, watchdog_s, dbg_s, scan_done_s;

   rsc_pkg::rsc_state_t state_r, state_nxt;
   logic [15:0] cnt_r;
   logic [5:0] cause_r, cause_nxt;
   logic [5:0] flags_r;
   logic por_boot_r;
   logic [2:0] win_r;
   logic sw_req_r;
   logic [5:0] src_w;
   logic any_src;
   logic scan_en;
   logic [15:0] startup_cyc;

   // Bus data phase tracking
   logic dp_wr_r;
   logic dp_rd_r;
   logic [7:0] dp_idx_r;
   logic ap_take;
   logic [7:0] ap_idx;
   logic wr_flags;
   logic wr_trig;
   logic trig_ok;

   // Two flip-flops for each of the six asynchronous inputs; no reset, so they settle while rst_i is high
   always_ff @(posedge clk_sys_i) begin
      sync1_r <= {memory_checksum_scan_done_i, single_pin_debug_port_req_i,
                  watchdog_timer_req_i, reset_pin_n_i, brownout_detector_i, por_low_i};
      sync2_r <= sync1_r;
   end

   assign por_s = sync2_r[0];
   assign brownout_s = sync2_r[1];
   assign pin_n_s = sync2_r[2];
   assign watchdog_s = sync2_r[3];
   assign dbg_s = sync2_r[4];
   assign scan_done_s = sync2_r[5];

   // Source vector in flag bit order
   always_comb begin
      src_w = '0;
      src_w[rsc_pkg::FLAG_POR] = por_s;
      src_w[rsc_pkg::FLAG_BROWNOUT] = brownout_s;
      src_w[rsc_pkg::FLAG_PIN] = reset_pin_function_field_i & ~pin_n_s;
      src_w[rsc_pkg::FLAG_WATCHDOG] = watchdog_s;
      src_w[rsc_pkg::FLAG_SW] = sw_req_r;
      src_w[rsc_pkg::FLAG_DBG] = dbg_s;
   end

   assign any_src = |src_w;
   assign scan_en = checksum_scan_source_field_i != rsc_pkg::SCAN_SRC_NONE;
   assign startup_cyc = 16'(STARTUP_UNIT_CYC) << startup_delay_fuse_field_i;

   // Sequence: hold, fuse reload, start-up delay, scan wait, run
   always_comb begin
      state_nxt = state_r;
      if (any_src) begin
         state_nxt = rsc_pkg::RS_HOLD;
      end else begin
         unique case (state_r)
            rsc_pkg::RS_HOLD: begin
               state_nxt = rsc_pkg::RS_LOAD;
            end
            rsc_pkg::RS_LOAD: begin
               if (cnt_r == 16'h0000) begin
                  state_nxt = rsc_pkg::RS_START;
               end
            end
            rsc_pkg::RS_START: begin
               if (cnt_r == 16'h0000) begin
                  state_nxt = scan_en ? rsc_pkg::RS_SCAN : rsc_pkg::RS_RUN;
               end
            end
            rsc_pkg::RS_SCAN: begin
               if (scan_done_s) begin
                  state_nxt = rsc_pkg::RS_RUN;
               end
            end
            rsc_pkg::RS_RUN: begin
               state_nxt = rsc_pkg::RS_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_r <= rsc_pkg::RS_HOLD;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Phase counter for fuse reload and start-up delay
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt_r <= rsc_pkg::FUSE_LOAD_CYC - 16'h0001;
      end else if (state_nxt == rsc_pkg::RS_HOLD) begin
         cnt_r <= rsc_pkg::FUSE_LOAD_CYC - 16'h0001;
      end else if (state_r == rsc_pkg::RS_LOAD && state_nxt == rsc_pkg::RS_START) begin
         cnt_r <= (startup_cyc == 16'h0000) ? 16'h0000 : startup_cyc - 16'h0001;
      end else if (cnt_r != 16'h0000 && state_r != rsc_pkg::RS_HOLD) begin
         cnt_r <= cnt_r - 16'h0001;
      end
   end

   // Causes gathered over one reset, used for domain selection
   always_comb begin
      if (state_r == rsc_pkg::RS_RUN) begin
         cause_nxt = src_w;
      end else begin
         cause_nxt = cause_r | src_w;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cause_r <= rsc_pkg::CAUSE_RST;
      end else begin
         cause_r <= cause_nxt;
      end
   end

   // Domain resets, released synchronously on entering run
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sys_reset_o <= 1'b1;
         debug_reset_o <= 1'b1;
         control_timer_override_reset_o <= 1'b1;
         fuse_reload_o <= 1'b0;
         memory_checksum_scan_start_o <= 1'b0;
      end else begin
         sys_reset_o <= state_nxt != rsc_pkg::RS_RUN;
         debug_reset_o <= (state_nxt != rsc_pkg::RS_RUN) &&
                          ((cause_nxt & rsc_pkg::MASK_SUPPLY) != 6'h00);
         control_timer_override_reset_o <= (state_nxt != rsc_pkg::RS_RUN) &&
                                           ((cause_nxt & rsc_pkg::MASK_POR) != 6'h00);
         fuse_reload_o <= state_nxt == rsc_pkg::RS_LOAD;
         memory_checksum_scan_start_o <= state_nxt == rsc_pkg::RS_SCAN;
      end
   end

   // Address phase decode
   assign ap_take = hsel_i && htrans_i[1] && hready_i;
   assign ap_idx = haddr_i[9:2];

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         dp_wr_r <= 1'b0;
         dp_rd_r <= 1'b0;
         dp_idx_r <= 8'h00;
      end else begin
         dp_wr_r <= ap_take && hwrite_i;
         dp_rd_r <= ap_take && !hwrite_i;
         dp_idx_r <= ap_idx;
      end
   end

   // Data phase write strobes
   assign wr_flags = dp_wr_r && dp_idx_r == rsc_pkg::IDX_CAUSE_FLAGS;
   assign wr_trig = dp_wr_r && dp_idx_r == rsc_pkg::IDX_SW_TRIGGER;
   assign trig_ok = wr_trig && win_r != 3'h0 && hwdata_i[rsc_pkg::SW_TRIGGER_BIT];

   // Unlock window counted in retired instructions
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         win_r <= 3'h0;
      end else if (io_register_unlock_key_i) begin
         win_r <= rsc_pkg::UNLOCK_WINDOW_INSTR;
      end else if (wr_trig) begin
         win_r <= 3'h0;
      end else if (instr_retired_i && win_r != 3'h0) begin
         win_r <= win_r - 3'h1;
      end
   end

   // Software request, one cycle, self-clearing
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sw_req_r <= 1'b0;
      end else begin
         sw_req_r <= trig_ok;
      end
   end

   // Boot after power-on not yet complete
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || por_s) begin
         por_boot_r <= 1'b1;
      end else if (state_r == rsc_pkg::RS_RUN) begin
         por_boot_r <= 1'b0;
      end
   end

   // Cause flags: set wins over write-one clear
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         flags_r <= rsc_pkg::FLAGS_RST;
      end else if (por_s) begin
         flags_r <= rsc_pkg::FLAGS_RST;
      end else begin
         flags_r <= (flags_r & ~(wr_flags ? hwdata_i[5:0] : 6'h00)) |
                    (src_w & (por_boot_r ? rsc_pkg::MASK_POR : 6'h3f));
      end
   end

   // Read data registered at the address phase, zero wait states
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         hrdata_o <= rsc_pkg::RDATA_RST;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         if (ap_take && !hwrite_i && ap_idx == rsc_pkg::IDX_CAUSE_FLAGS) begin
            hrdata_o <= {26'h0000000, flags_r};
         end else begin
            hrdata_o <= rsc_pkg::RDATA_RST;
         end
      end
   end

   // Checks
   a_sw_trig_reset: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      trig_ok |=> sw_req_r ##1 sys_reset_o)
      else $error("software trigger did not start reset");

   a_locked_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (wr_trig && win_r == 3'h0) |=> !sw_req_r)
      else $error("locked trigger write took effect");

   a_por_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      por_s |=> sys_reset_o && control_timer_override_reset_o && debug_reset_o)
      else $error("power-on did not hold all domains");

   a_pin_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (reset_pin_function_field_i && !pin_n_s) |=> sys_reset_o)
      else $error("pin low did not hold reset");

   a_domain_nest: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (control_timer_override_reset_o |-> debug_reset_o) and
      (debug_reset_o |-> sys_reset_o))
      else $error("domain resets not nested");

   a_por_flags: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      por_s |=> flags_r == rsc_pkg::FLAGS_RST)
      else $error("flags wrong after power-on");

   a_trig_reads: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (ap_take && !hwrite_i && ap_idx == rsc_pkg::IDX_SW_TRIGGER) |=> hrdata_o == 32'h0)
      else $error("trigger register read nonzero");

   a_release_clean: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $fell(sys_reset_o) |-> !$past(any_src) && $past(state_r) != rsc_pkg::RS_HOLD)
      else $error("reset released while a source active");

   a_scan_wait: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state_r == rsc_pkg::RS_SCAN && !scan_done_s) |=> sys_reset_o)
      else $error("reset released before scan done");

   a_set_wins: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!por_s && !por_boot_r && src_w[rsc_pkg::FLAG_WATCHDOG]) |=>
      flags_r[rsc_pkg::FLAG_WATCHDOG])
      else $error("watchdog flag lost");

   a_load_count: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state_r == rsc_pkg::RS_LOAD && $past(state_r) == rsc_pkg::RS_HOLD) |->
      cnt_r == rsc_pkg::FUSE_LOAD_CYC - 16'h0001)
      else $error("fuse reload length wrong");

   a_start_len: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (state_r == rsc_pkg::RS_LOAD && state_nxt == rsc_pkg::RS_START) |=>
      cnt_r == startup_cyc - 16'h0001)
      else $error("start-up delay count wrong");

   a_trig_self_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      sw_req_r |=> !sw_req_r)
      else $error("software request did not self-clear");

endmodule
